//--- rtl/cpu_regs.sv
// processor state registers, stack engine and memory map decode
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "cpu_regs_consts.svh"
module cpu_regs
   import cpu_regs_pkg::*;
#(
   parameter int RAM_BYTES = 1536
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic srst,
   input wire logic clkEn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // flash vector bytes
   input wire logic [7:0] vecByte0,
   input wire logic [7:0] vecByte1,
   // decode results
   output logic [1:0] regionOut,
   output logic fetchFault,
   output logic [1:0] bankOut
);
   initial begin
      if (RAM_BYTES != 1536) $error("ram size must be 1536");
   end

   typedef struct packed {
      logic [19:0] pc;
      logic [7:0] status_word;
      logic [15:0] sp;
      logic mirror;
      logic mirrorWait;
      logic [31:0] opnd;
      logic [19:0] addr;
      logic [7:0] intReq;
      logic [1:0] cnt;
      logic [31:0] pushData;
      logic [2:0] pushLeft;
      state_t st;
      logic busy;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic [1:0] region;
      logic fault;
      logic [1:0] bank;
   } state_s_t;

   state_s_t cur_ff;
   state_s_t nxt_cur;

   // ram bytes kept outside the state record, one write port
   // an unpacked array cannot live inside the packed record
   logic [7:0] ram_ff [RAM_BYTES];
   logic ramWe;
   logic [10:0] ramWa;
   logic [7:0] ramWd;

   // ram byte index from a 20-bit address
   function automatic logic [10:0] ramIdx(input logic [19:0] a);
      logic [19:0] d;
      d = a - `RAM_LO;
      return d[10:0];
   endfunction

   // address inside internal ram
   function automatic logic inRam(input logic [19:0] a);
      return (a >= `RAM_LO) && (a <= `RAM_HI);
   endfunction

   // sixteen bit stack pointer placed in the ram page
   function automatic logic [19:0] spAddr(input logic [15:0] s);
      return {4'hf, s};
   endfunction

   // bus window slot to ram index, top 128 bytes incl. banks
   function automatic logic [10:0] winIdx(input logic [11:0] a);
      return 11'h580 + 11'(a[8:2]);
   endfunction

   logic [19:0] spFull;
   logic [15:0] spM1, spM2, spM4;
   logic [15:0] spP1;
   logic access, wr;
   logic [7:0] res8;
   logic [8:0] sum9;
   logic [4:0] nib;
   logic [1:0] reqPri;
   logic reqOk;

   assign spFull = spAddr(cur_ff.sp);
   assign spM1 = cur_ff.sp - 16'h0001;
   assign spM2 = cur_ff.sp - 16'h0002;
   assign spM4 = cur_ff.sp - 16'h0004;
   // odd byte of a two byte status frame
   assign spP1 = cur_ff.sp + 16'h0001;
   assign access = psel && penable && !cur_ff.ready;
   assign wr = access && pwrite;

   // next state
   always_comb begin
      nxt_cur = cur_ff;
      sum9 = 9'h000;
      nib = 5'h00;
      res8 = 8'h00;
      reqPri = 2'b00;
      reqOk = 1'b0;
      ramWe = 1'b0;
      ramWa = 11'h000;
      ramWd = 8'h00;
      nxt_cur.ready = 1'b0;
      nxt_cur.slverr = 1'b0;
      // engine for vector load and multi byte stack traffic
      case (cur_ff.st)
         ST_IDLE: begin
         end
         ST_VEC0: begin
            nxt_cur.pc = {4'h0, vecByte1, vecByte0};
            nxt_cur.st = ST_IDLE;
            nxt_cur.busy = 1'b0;
         end
         ST_VEC1: begin
            nxt_cur.st = ST_VEC0;
         end
         ST_PUSH: begin
            // top byte of the frame goes to the lowered pointer
            nxt_cur.sp = spM1;
            ramWe = 1'b1;
            ramWa = ramIdx(spAddr(spM1));
            ramWd = cur_ff.pushData[31:24];
            nxt_cur.pushData = {cur_ff.pushData[23:0], 8'h00};
            nxt_cur.pushLeft = cur_ff.pushLeft - 3'd1;
            if (cur_ff.pushLeft == 3'd1) begin
               nxt_cur.st = ST_IDLE;
               nxt_cur.busy = 1'b0;
            end
         end
         ST_POP: begin
            // status sits in the odd byte of a two byte frame
            nxt_cur.status_word = ram_ff[ramIdx(spAddr(spP1))];
            // two bytes keep bit 0 clear
            nxt_cur.sp = cur_ff.sp + 16'h0002;
            nxt_cur.st = ST_IDLE;
            nxt_cur.busy = 1'b0;
         end
         default: nxt_cur.st = ST_IDLE;
      endcase
      // mirror usable one instruction after write
      if (wr && paddr == `A_CMD && pwdata[3:0] != 4'(CMD_NOP)) begin
         nxt_cur.mirrorWait = 1'b0;
      end
      if (access) begin
         nxt_cur.ready = 1'b1;
         nxt_cur.rdata = 32'h0000_0000;
         case (paddr)
            `A_PC: nxt_cur.rdata = {12'h000, cur_ff.pc};
            `A_PSW: nxt_cur.rdata = {24'h000000, cur_ff.status_word};
            `A_SP: nxt_cur.rdata = {16'h0000, cur_ff.sp};
            `A_MIRROR: nxt_cur.rdata = {31'h0, cur_ff.mirror};
            `A_OPND: nxt_cur.rdata = cur_ff.opnd;
            `A_ADDR: nxt_cur.rdata = {12'h000, cur_ff.addr};
            `A_STAT: nxt_cur.rdata = {26'h0, cur_ff.mirrorWait, cur_ff.fault,
               cur_ff.region, cur_ff.bank != 2'b00, cur_ff.busy};
            `A_INTREQ: nxt_cur.rdata = {24'h000000, cur_ff.intReq};
            `A_CMD: nxt_cur.rdata = 32'h0000_0000;
            default: begin
               if (paddr >= `A_RAMWIN && paddr < `A_RAMWIN + 12'h200) begin
                  nxt_cur.rdata = {24'h000000, ram_ff[winIdx(paddr)]};
               end else begin
                  nxt_cur.slverr = 1'b1;
               end
            end
         endcase
         if (pwrite) begin
            case (paddr)
               `A_OPND: nxt_cur.opnd = pwdata;
               `A_ADDR: begin
                  nxt_cur.addr = pwdata[19:0];
                  nxt_cur.region = (pwdata[19:0] >= `SFR_LO) ? REG_SFR :
                     (pwdata[19:0] >= `XSFR_LO && pwdata[19:0] <= `XSFR_HI) ?
                     REG_XSFR : REG_NONE;
                  nxt_cur.fault = (pwdata[19:0] >= `MIR_LO && !inRam(pwdata[19:0]))
                     || pwdata[19:0] >= `BANK_LO;
               end
               `A_MIRROR: begin
                  nxt_cur.mirror = pwdata[0];
                  nxt_cur.mirrorWait = 1'b1;
               end
               `A_INTREQ: nxt_cur.intReq = pwdata[7:0];
               `A_CMD: begin
                  if (cur_ff.busy) begin
                     nxt_cur.slverr = 1'b1;
                  end else begin
                     case (cmd_t'(pwdata[3:0]))
                        CMD_STEP: nxt_cur.pc = cur_ff.pc + 20'(cur_ff.opnd[2:0])
                           + 20'(cur_ff.region == REG_XSFR);
                        CMD_BRANCH: nxt_cur.pc = cur_ff.opnd[19:0];
                        CMD_ALU: begin
                           // carry out of add or subtract
                           if (cur_ff.opnd[16]) begin
                              sum9 = {1'b0, cur_ff.opnd[7:0]} - {1'b0, cur_ff.opnd[15:8]};
                              nib = {1'b0, cur_ff.opnd[3:0]} - {1'b0, cur_ff.opnd[11:8]};
                           end else begin
                              sum9 = {1'b0, cur_ff.opnd[7:0]} + {1'b0, cur_ff.opnd[15:8]};
                              nib = {1'b0, cur_ff.opnd[3:0]} + {1'b0, cur_ff.opnd[11:8]};
                           end
                           res8 = sum9[7:0];
                           nxt_cur.status_word[`PSW_Z] = (res8 == 8'h00);
                           // carry or borrow at bit 3
                           nxt_cur.status_word[`PSW_AC] = nib[4];
                           nxt_cur.status_word[`PSW_CY] = sum9[8];
                        end
                        CMD_SELBANK: begin
                           nxt_cur.status_word[`PSW_BANK_SELECT_HIGH] = cur_ff.opnd[1];
                           nxt_cur.status_word[`PSW_BANK_SELECT_LOW] = cur_ff.opnd[0];
                        end
                        CMD_MASK: nxt_cur.status_word[`PSW_IE] = 1'b0;
                        CMD_UNMASK: nxt_cur.status_word[`PSW_IE] = 1'b1;
                        CMD_INTACK: begin
                           reqPri = cur_ff.intReq[1:0];
                           reqOk = cur_ff.status_word[`PSW_IE] && cur_ff.intReq[7] &&
                              reqPri <= {cur_ff.status_word[`PSW_SERVICE_PRIORITY_HIGH], cur_ff.status_word[`PSW_SERVICE_PRIORITY_LOW]};
                           if (reqOk) begin
                              nxt_cur.status_word[`PSW_IE] = 1'b0;
                              // two byte frame keeps pointer even
                              nxt_cur.pushData = {cur_ff.status_word, 8'h00, 16'h0000};
                              nxt_cur.pushLeft = 3'd2;
                              nxt_cur.st = ST_PUSH;
                              nxt_cur.busy = 1'b1;
                           end
                        end
                        // status at sp-1, filler at sp-2
                        CMD_PUSHPSW: begin
                           nxt_cur.pushData = {cur_ff.status_word, 8'h00, 16'h0000};
                           nxt_cur.pushLeft = 3'd2;
                           nxt_cur.st = ST_PUSH;
                           nxt_cur.busy = 1'b1;
                        end
                        CMD_POPPSW, CMD_INTERRUPT_RETURN_INSTR: begin
                           nxt_cur.st = ST_POP;
                           nxt_cur.busy = 1'b1;
                        end
                        CMD_CALL: begin
                           nxt_cur.pushData = {8'h00, 4'h0, cur_ff.pc[19:16],
                              cur_ff.pc[15:8], cur_ff.pc[7:0]};
                           nxt_cur.pushLeft = 3'd4;
                           nxt_cur.st = ST_PUSH;
                           nxt_cur.busy = 1'b1;
                        end
                        // pair push high byte first at sp-1
                        CMD_PUSHRP: begin
                           nxt_cur.pushData = {cur_ff.opnd[15:8], cur_ff.opnd[7:0], 16'h0000};
                           nxt_cur.pushLeft = 3'd2;
                           nxt_cur.st = ST_PUSH;
                           nxt_cur.busy = 1'b1;
                        end
                        CMD_LDSP: nxt_cur.sp = {cur_ff.opnd[15:1], 1'b0};
                        CMD_RESET: begin
                           nxt_cur.st = ST_VEC1;
                           nxt_cur.busy = 1'b1;
                        end
                        default: begin
                        end
                     endcase
                  end
               end
               default: begin
                  // bank registers live in ram
                  // a window write in a push cycle wins, so poll busy first
                  if (paddr >= `A_RAMWIN && paddr < `A_RAMWIN + 12'h200) begin
                     ramWe = 1'b1;
                     ramWa = winIdx(paddr);
                     ramWd = pwdata[7:0];
                  end
               end
            endcase
         end
      end
      nxt_cur.bank = {nxt_cur.status_word[`PSW_BANK_SELECT_HIGH], nxt_cur.status_word[`PSW_BANK_SELECT_LOW]};
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         cur_ff.pc <= 20'h00000;
         cur_ff.status_word <= `PSW_RST;
         cur_ff.sp <= 16'h0000;
         cur_ff.mirror <= 1'b0;
         cur_ff.mirrorWait <= 1'b0;
         cur_ff.opnd <= 32'h0000_0000;
         cur_ff.addr <= 20'h00000;
         cur_ff.intReq <= 8'h00;
         cur_ff.cnt <= 2'b00;
         cur_ff.pushData <= 32'h0000_0000;
         cur_ff.pushLeft <= 3'd0;
         cur_ff.st <= ST_VEC1;
         cur_ff.busy <= 1'b1;
         cur_ff.rdata <= 32'h0000_0000;
         cur_ff.ready <= 1'b0;
         cur_ff.slverr <= 1'b0;
         cur_ff.region <= 2'b00;
         cur_ff.fault <= 1'b0;
         cur_ff.bank <= 2'b00;
      end else if (clkEn) begin
         cur_ff <= nxt_cur;
      end
   end

   // ram write port, frozen with the rest of the state
   // contents are left alone by reset, like the real array
   always_ff @(posedge clk) begin
      if (clkEn && ramWe) begin
         ram_ff[ramWa] <= ramWd;
      end
   end

   // outputs straight from the state record
   assign prdata = cur_ff.rdata;
   assign pready = cur_ff.ready;
   assign pslverr = cur_ff.slverr;
   assign regionOut = cur_ff.region;
   assign fetchFault = cur_ff.fault;
   assign bankOut = cur_ff.bank;
endmodule

//--- shared/cpu_regs_consts.svh
// constants for the cpu processor register block
// Summary of operation
// - ram spans ff900 to ffeff
// - four banks of eight byte registers
// - peripheral registers decode fff00 to fffff
// - extended peripheral registers f0000 to f07ff
// - pc advances by length or branches
// - reset loads pc from vector bytes
// - status word layout, resets to 06
// - status pushed on interrupt, restored on returns
// - enable flag masks, cleared by mask
// - zero flag follows zero result
// - bank select bits pick bank
// - half carry from bit three
// - lower priority than service level refused
// - carry holds add or subtract overflow
// - sixteen bit stack pointer, bit0 zero
// - decrement before save, increment after restore
// - call pushes four bytes, 00 then pc
// - flash mirrored read only, no fetch
`ifndef CPU_REGS_CONSTS_SVH
`define CPU_REGS_CONSTS_SVH
`define RAM_LO 20'hff900
`define RAM_HI 20'hffeff
`define BANK_LO 20'hffee0
`define SFR_LO 20'hfff00
`define XSFR_LO 20'hf0000
`define XSFR_HI 20'hf07ff
`define MIR_LO 20'hf0000
`define VEC_LO 20'h00000
`define VEC_HI 20'h00001
`define PSW_RST 8'h06
`define PSW_IE 7
`define PSW_Z 6
`define PSW_BANK_SELECT_HIGH 5
`define PSW_AC 4
`define PSW_BANK_SELECT_LOW 3
`define PSW_SERVICE_PRIORITY_HIGH 2
`define PSW_SERVICE_PRIORITY_LOW 1
`define PSW_CY 0
`define A_PC 12'h000
`define A_PSW 12'h004
`define A_SP 12'h008
`define A_MIRROR 12'h00c
`define A_CMD 12'h010
`define A_OPND 12'h014
`define A_ADDR 12'h018
`define A_STAT 12'h01c
`define A_INTREQ 12'h020
`define A_RAMWIN 12'h400
`endif

//--- shared/cpu_regs_pkg.sv
// types for the cpu processor register block
package cpu_regs_pkg;
   typedef enum logic [3:0] {
      CMD_NOP, CMD_STEP, CMD_BRANCH, CMD_ALU, CMD_SELBANK, CMD_MASK, CMD_UNMASK,
      CMD_INTACK, CMD_PUSHPSW, CMD_POPPSW, CMD_INTERRUPT_RETURN_INSTR, CMD_CALL, CMD_PUSHRP, CMD_LDSP,
      CMD_RESET
   } cmd_t;
   typedef enum logic [2:0] {ST_IDLE, ST_VEC0, ST_VEC1, ST_PUSH, ST_POP} state_t;
   typedef enum logic [1:0] {REG_NONE, REG_SFR, REG_XSFR} region_t;
endpackage

//--- testbench/cpu_regs_props.sv
// assertion checker for the cpu register block ports
`timescale 1ns/1ns
`include "cpu_regs_consts.svh"
module cpu_regs_checker #(
   parameter int RAM_BYTES = 1536
) (
   // clock and control
   input wire logic clk,
   input wire logic srst,
   input wire logic clkEn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // decode outputs
   input wire logic [1:0] regionOut,
   input wire logic fetchFault,
   input wire logic [1:0] bankOut
);
   // address writes answered without error, and any answered command write
   wire addrWr = pready && pwrite && paddr == `A_ADDR && !pslverr;
   wire cmdWr = pready && pwrite && paddr == `A_CMD;
   wire [19:0] wa = pwdata[19:0];
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_ready_held: assert property (pready |-> psel && penable)
      else $error("ready outside an access");
   a_ready_once: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_access_answer: assert property (psel && penable && !pready && clkEn |=> pready)
      else $error("access not answered");
   a_err_unmapped: assert property (
      pready && paddr inside {[12'h024:12'h3fc]} |-> pslverr) else $error("no error");
   a_region_sfr: assert property (
      addrWr && wa >= 20'hfff00 |-> ##[1:2] regionOut == 2'h1) else $error("sfr decode");
   a_region_ext: assert property (
      addrWr && wa <= 20'hf07ff && wa >= 20'hf0000 |-> ##[1:2] regionOut == 2'h2)
      else $error("ext decode");
   a_fetch_bank: assert property (
      addrWr && wa inside {[20'hffee0:20'hffeff]} |-> ##[1:2] fetchFault)
      else $error("bank fetch allowed");
   a_fetch_ram: assert property (
      addrWr && wa inside {[20'hff900:20'hffedf]} |-> ##[1:2] !fetchFault)
      else $error("ram fetch refused");
   a_fetch_mirror: assert property (
      addrWr && wa inside {[20'hf0000:20'hff8ff]} |-> ##[1:2] fetchFault)
      else $error("mirror fetch allowed");
   a_bank_reset: assert property ($fell(srst) |-> bankOut == 2'h0)
      else $error("bank not zero after reset");
   a_bank_cause: assert property (!$stable(bankOut) |-> cmdWr || $past(cmdWr) ||
      $past(cmdWr, 2) || $past(cmdWr, 3) || $past(cmdWr, 4)) else $error("bank moved");
   // main scenarios reached
   c_addr: cover property (addrWr);
   c_err: cover property (pready && pslverr);
   c_bank: cover property (!$stable(bankOut));
endmodule
bind cpu_regs cpu_regs_checker #(.RAM_BYTES(RAM_BYTES)) cpu_regs_checker_inst (
   .clk(clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .regionOut(regionOut), .fetchFault(fetchFault), .bankOut(bankOut));

//--- testbench/flash_vector_model.sv
// reset vector bytes as seen from the code flash
`timescale 1ns/1ns
module flash_vector_model #(
   parameter logic [7:0] LOW_BYTE = 8'h34,
   parameter logic [7:0] HIGH_BYTE = 8'h12
) (
   // vector table bytes
   output logic [7:0] vecByte0,
   output logic [7:0] vecByte1
);
   assign vecByte0 = LOW_BYTE;
   assign vecByte1 = HIGH_BYTE;
endmodule

//--- testbench/tb_cpu_processor_registers_memory_map.sv
// self-checking bench for the cpu register block
`timescale 1ns/1ns
`include "cpu_regs_consts.svh"
module tb_cpu_processor_registers_memory_map;
   import cpu_regs_pkg::*;
   localparam logic [7:0] VLO = 8'h34;
   localparam logic [7:0] VHI = 8'h12;
   logic clk = 1'b0, srst = 1'b1, clkEn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, fetchFault;
   logic [7:0] vecByte0, vecByte1;
   logic [1:0] regionOut, bankOut;
   int nMismatch = 0, samplesChecked = 0, cycles = 0;
   // design and flash partner
   cpu_regs cpu_regs_inst (.clk(clk), .srst(srst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .vecByte0(vecByte0), .vecByte1(vecByte1),
      .regionOut(regionOut), .fetchFault(fetchFault), .bankOut(bankOut));
   flash_vector_model #(.LOW_BYTE(VLO), .HIGH_BYTE(VHI)) flash_vector_model_inst (
      .vecByte0(vecByte0), .vecByte1(vecByte1));
   // 100 ns clock
   initial begin
      forever #50 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         nMismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until ready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) nMismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   // poll busy before the next command
   task idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, `A_STAT, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 40);
   endtask
   task cmd(input cmd_t c, input logic [31:0] o);
      apb(1'b1, `A_OPND, o);
      apb(1'b1, `A_CMD, {28'h0, c});
      idle;
   endtask
   task t_reset;
      idle;
      rdm(`A_PSW, 32'hffffffff, 32'h6);
      rdm(`A_PC, 32'hffffffff, {16'h0, VHI, VLO});
      chk({30'h0, bankOut}, 32'h0);
      $display("reset test done");
   endtask
   task t_pc;
      cmd(CMD_STEP, 32'h3);
      rdm(`A_PC, 32'hffffffff, {16'h0, VHI, VLO} + 32'h3);
      apb(1'b1, `A_ADDR, 32'hf0010);
      cmd(CMD_STEP, 32'h3);
      rdm(`A_PC, 32'hffffffff, {16'h0, VHI, VLO} + 32'h7);
      cmd(CMD_BRANCH, 32'habcde);
      rdm(`A_PC, 32'hffffffff, 32'habcde);
      $display("program counter test done");
   endtask
   task t_alu;
      logic [31:0] ops [0:4] = '{32'h0808, 32'h01ff, 32'h10110, 32'h10100, 32'h10505};
      logic [31:0] flg [0:4] = '{32'h10, 32'h51, 32'h10, 32'h11, 32'h40};
      for (int i = 0; i < 5; i++) begin
         cmd(CMD_ALU, ops[i]);
         rdm(`A_PSW, 32'h51, flg[i]);
      end
      $display("flag test done");
   endtask
   task t_bank;
      for (int b = 0; b < 4; b++) begin
         cmd(CMD_SELBANK, 32'(b));
         chk({30'h0, bankOut}, 32'(b));
         rdm(`A_PSW, 32'h28, {26'h0, b[1], 1'b0, b[0], 3'h0});
      end
      $display("bank test done");
   endtask
   task t_stack;
      cmd(CMD_LDSP, 32'hfe01);
      rdm(`A_SP, 32'hffffffff, 32'hfe00);
      cmd(CMD_CALL, 32'h0);
      rdm(`A_SP, 32'hffffffff, 32'hfdfc);
      cmd(CMD_PUSHRP, 32'hbeef);
      rdm(`A_SP, 32'hffffffff, 32'hfdfa);
      cmd(CMD_UNMASK, 32'h0);
      for (int k = 0; k < 2; k++) begin
         cmd(CMD_PUSHPSW, 32'h0);
         cmd(CMD_MASK, 32'h0);
         rdm(`A_PSW, 32'h80, 32'h0);
         cmd(k == 0 ? CMD_POPPSW : CMD_INTERRUPT_RETURN_INSTR, 32'h0);
         rdm(`A_PSW, 32'ha8, 32'ha8);
         rdm(`A_SP, 32'hffffffff, 32'hfdfa);
      end
      apb(1'b1, `A_INTREQ, 32'h83);
      cmd(CMD_INTACK, 32'h0);
      rdm(`A_PSW, 32'h80, 32'h0);
      rdm(`A_SP, 32'hffffffff, 32'hfdf8);
      $display("stack test done");
   endtask
   task t_map;
      logic [19:0] ad [0:6] = '{20'hff900, 20'hffedf, 20'hffee0, 20'hfff10, 20'hf0010,
         20'hf0800, 20'h00100};
      logic [2:0] ex [0:6] = '{3'h0, 3'h0, 3'h1, 3'h3, 3'h5, 3'h1, 3'h0};
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, `A_ADDR, {12'h0, ad[i]});
         rdm(`A_STAT, 32'h1c, {27'h0, ex[i][0], ex[i][2:1], 2'h0});
         chk({29'h0, regionOut, fetchFault}, {29'h0, ex[i]});
      end
      apb(1'b1, `A_RAMWIN, 32'ha5);
      rdm(`A_RAMWIN, 32'hff, 32'ha5);
      apb(1'b1, 12'h580, 32'h5a);
      rdm(12'h580, 32'hff, 32'h5a);
      apb(1'b0, 12'h024, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `A_MIRROR, 32'h0);
      rdm(`A_MIRROR, 32'h1, 32'h0);
      rdm(`A_STAT, 32'h20, 32'h20);
      cmd(CMD_STEP, 32'h0);
      rdm(`A_STAT, 32'h20, 32'h0);
      $display("map test done");
   endtask
   task wrapUp;
      $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         nMismatch++;
         wrapUp;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_reset;
      t_pc;
      t_alu;
      t_bank;
      t_stack;
      t_map;
      wrapUp;
   end
endmodule
